// ---- verilog/cnec_node_ctrl.sv ----
// Notes on behaviour
// - time stamp counts actual bit times, including resynchronization effects
// - error counter reaching warning level (default 0x60) sets warning and irq
// - tec above 255: bus-off, both counters to 1, offline set, irq
// - recovery starts alone; receive count rises once per idle time
// - receive count 0x60 in recovery shows warning with bus-off, irq
// - after 128 idle times clear warning and bus-off, alert, stay offline
// - node disable set: wait for bus idle, then set suspend acknowledge
// - suspend acknowledge is status only, no other effect
// - receive pin passes two flip-flops before the protocol samples it
// - single trial: clear transmit request at selection, never retransmit
// - single trial: error before start of frame drops the message
// - suspend enabled and requested: go offline once idle or bus-off
`include "cnec_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module cnec_node_ctrl
	import cnec_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic rx_pin_in,
	input wire logic bit_tick_in,
	input wire logic bus_idle_in,
	input wire logic idle_seen_in,
	input wire logic tx_err_in,
	input wire logic tx_ok_in,
	input wire logic rx_err_in,
	input wire logic rx_ok_in,
	input wire logic frame_err_in,
	input wire logic warn_level_wr_in,
	input wire logic [7:0] warn_level_in,
	input wire logic offline_set_in,
	input wire logic offline_clr_in,
	input wire logic node_disable_bit_in,
	input wire logic suspend_sensitivity_enable_in,
	input wire logic suspend_req_in,
	input wire logic single_transmit_trial_in,
	input wire logic transmit_request_bit_set_in,
	input wire logic wr_valid_in,
	input wire logic [7:0] wr_data_in,
	output logic wr_ready_out,
	output logic tx_out,
	output logic rx_sampled_out,
	output logic [15:0] timestamp_out,
	output logic [8:0] tec_out,
	output logic [7:0] rec_out,
	output logic error_warning_flag_out,
	output logic bus_off_flag_out,
	output logic node_offline_out,
	output logic suspend_acknowledge_out,
	output logic transmit_request_bit_out,
	output logic warn_irq_out,
	output logic bus_off_flag_irq_out,
	output logic alert_irq_out
);
	logic [1:0] rx_sync_r;
	logic [15:0] ts_r, ts_nxt;
	logic [8:0] tec_r, tec_nxt;
	logic [7:0] rec_r, rec_nxt, lvl_r, lvl_nxt, idle_cnt_r, idle_cnt_nxt;
	logic error_warning_flag_r, error_warning_flag_nxt, bus_off_flag_r, bus_off_flag_nxt, off_r, off_nxt;
	logic sack_r, sack_nxt, wirq_r, wirq_nxt, birq_r, birq_nxt;
	logic airq_r, airq_nxt, error_warning_flag_new, susp_go;
	cnec_tx_state_t st_r, st_nxt;
	logic transmit_request_bit_r, transmit_request_bit_nxt, tx_r, tx_nxt, have_r, have_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [2:0] bits_r, bits_nxt;
	logic [7:0] buf_r [0:1];
	logic [1:0] cnt_r, cnt_nxt;
	logic wp_r, wp_nxt, rp_r, rp_nxt, push, pop;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rx_sync_r <= {2{`CNEC_RECESSIVE}};
		end else begin
			rx_sync_r <= {rx_sync_r[0], rx_pin_in};
		end
	end
	assign susp_go = suspend_sensitivity_enable_in && suspend_req_in &&
		(bus_idle_in || bus_off_flag_r);
	always_comb begin
		ts_nxt = ts_r;
		tec_nxt = tec_r;
		rec_nxt = rec_r;
		lvl_nxt = lvl_r;
		idle_cnt_nxt = idle_cnt_r;
		error_warning_flag_nxt = error_warning_flag_r;
		bus_off_flag_nxt = bus_off_flag_r;
		off_nxt = off_r;
		wirq_nxt = 1'b0;
		birq_nxt = 1'b0;
		airq_nxt = 1'b0;
		error_warning_flag_new = 1'b0;
		// one step per actual bit time
		if (bit_tick_in) begin
			ts_nxt = ts_r + 16'h0001;
		end
		if (warn_level_wr_in) begin
			lvl_nxt = warn_level_in;
		end
		if (!bus_off_flag_r) begin
			if (tx_err_in) begin
				tec_nxt = tec_r + `CNEC_TEC_ERR_INC;
			end else if (tx_ok_in && tec_r != 9'h000) begin
				tec_nxt = tec_r - `CNEC_CNT_ONE_TEC;
			end
			if (rx_err_in && rec_r != `CNEC_REC_MAX) begin
				rec_nxt = rec_r + `CNEC_CNT_ONE_REC;
			end else if (rx_ok_in && rec_r != 8'h00) begin
				rec_nxt = rec_r - `CNEC_CNT_ONE_REC;
			end
			if (tec_nxt > `CNEC_TEC_BUS_OFF_FLAG_LIM) begin
				tec_nxt = `CNEC_CNT_ONE_TEC;
				rec_nxt = `CNEC_CNT_ONE_REC;
				bus_off_flag_nxt = 1'b1;
				error_warning_flag_nxt = 1'b0;
				birq_nxt = 1'b1;
				idle_cnt_nxt = 8'h00;
			end else begin
				error_warning_flag_new = ({1'b0, lvl_r} <= tec_nxt) || (lvl_r <= rec_nxt);
				error_warning_flag_nxt = error_warning_flag_new;
				wirq_nxt = error_warning_flag_new && !error_warning_flag_r;
			end
		end else if (idle_seen_in) begin
			// recovery needs no software, one step per idle
			rec_nxt = rec_r + `CNEC_CNT_ONE_REC;
			idle_cnt_nxt = idle_cnt_r + 8'h01;
			// pre-warning: end of recovery is near
			if (rec_nxt == `CNEC_WARN_DEF) begin
				error_warning_flag_nxt = 1'b1;
				wirq_nxt = 1'b1;
			end
			// recovery done; offline stays for software
			if (idle_cnt_nxt == `CNEC_RECOV_IDLES) begin
				error_warning_flag_nxt = 1'b0;
				bus_off_flag_nxt = 1'b0;
				tec_nxt = 9'h000;
				rec_nxt = 8'h00;
				airq_nxt = 1'b1;
			end
		end
		// hardware forcing wins over a software clear
		if (offline_clr_in) begin
			off_nxt = 1'b0;
		end
		// go offline at once; a running frame still finishes
		if (offline_set_in || birq_nxt || susp_go) begin
			off_nxt = 1'b1;
		end
	end
	// acknowledge once the bus has gone idle, or at once on a suspend request in bus-off
	always_comb begin
		sack_nxt = 1'b0;
		if (node_disable_bit_in || susp_go) begin
			sack_nxt = sack_r || bus_idle_in || susp_go;
		end else if (suspend_sensitivity_enable_in && suspend_req_in) begin
			sack_nxt = sack_r;
		end
	end
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ts_r <= 16'h0000;
			tec_r <= 9'h000;
			rec_r <= 8'h00;
			lvl_r <= `CNEC_WARN_DEF;
			idle_cnt_r <= 8'h00;
			error_warning_flag_r <= 1'b0;
			bus_off_flag_r <= 1'b0;
			off_r <= 1'b1;
			sack_r <= 1'b0;
			wirq_r <= 1'b0;
			birq_r <= 1'b0;
			airq_r <= 1'b0;
		end else begin
			ts_r <= ts_nxt;
			tec_r <= tec_nxt;
			rec_r <= rec_nxt;
			lvl_r <= lvl_nxt;
			idle_cnt_r <= idle_cnt_nxt;
			error_warning_flag_r <= error_warning_flag_nxt;
			bus_off_flag_r <= bus_off_flag_nxt;
			off_r <= off_nxt;
			sack_r <= sack_nxt;
			wirq_r <= wirq_nxt;
			birq_r <= birq_nxt;
			airq_r <= airq_nxt;
		end
	end
	// two-entry word buffer; a full buffer stalls the writer
	assign wr_ready_out = (cnt_r != `CNEC_BUF_FULL);
	assign push = wr_valid_in && wr_ready_out;
	assign pop = (st_r == cnec_st_frame) && !have_r && (cnt_r != 2'h0);
	always_comb begin
		st_nxt = st_r;
		transmit_request_bit_nxt = transmit_request_bit_r;
		tx_nxt = tx_r;
		sh_nxt = sh_r;
		bits_nxt = bits_r;
		have_nxt = have_r;
		wp_nxt = wp_r ^ push;
		rp_nxt = rp_r ^ pop;
		cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
		unique case (st_r)
			cnec_st_idle: begin
				tx_nxt = `CNEC_RECESSIVE;
				if (transmit_request_bit_r && !off_r && bus_idle_in) begin
					st_nxt = cnec_st_sel;
					// single trial drops the request at selection
					if (single_transmit_trial_in) begin
						transmit_request_bit_nxt = 1'b0;
					end
				end
			end
			cnec_st_sel: begin
				// error before start of frame: request stays as is
				if (frame_err_in || off_r) begin
					st_nxt = cnec_st_idle;
				end else if (bit_tick_in) begin
					tx_nxt = `CNEC_DOMINANT;
					st_nxt = cnec_st_frame;
				end
			end
			cnec_st_frame: begin
				if (frame_err_in) begin
					// without single trial the request stays and retries
					tx_nxt = `CNEC_RECESSIVE;
					have_nxt = 1'b0;
					st_nxt = cnec_st_idle;
				end else if (pop) begin
					sh_nxt = buf_r[rp_r];
					bits_nxt = 3'h0;
					have_nxt = 1'b1;
				end else if (bit_tick_in && have_r) begin
					tx_nxt = sh_r[7];
					sh_nxt = {sh_r[6:0], 1'b0};
					bits_nxt = bits_r + 3'h1;
					have_nxt = (bits_r != `CNEC_BIT_LAST);
				end else if (bit_tick_in) begin
					tx_nxt = `CNEC_RECESSIVE;
					transmit_request_bit_nxt = 1'b0;
					st_nxt = cnec_st_idle;
				end
			end
		endcase
		// a software set beats a same-cycle hardware clear
		if (transmit_request_bit_set_in) begin
			transmit_request_bit_nxt = 1'b1;
		end
	end
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_r <= cnec_st_idle;
			transmit_request_bit_r <= 1'b0;
			tx_r <= `CNEC_RECESSIVE;
			sh_r <= 8'h00;
			bits_r <= 3'h0;
			have_r <= 1'b0;
			cnt_r <= 2'h0;
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			buf_r[0] <= 8'h00;
			buf_r[1] <= 8'h00;
		end else begin
			st_r <= st_nxt;
			transmit_request_bit_r <= transmit_request_bit_nxt;
			tx_r <= tx_nxt;
			sh_r <= sh_nxt;
			bits_r <= bits_nxt;
			have_r <= have_nxt;
			cnt_r <= cnt_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			if (push) begin
				buf_r[wp_r] <= wr_data_in;
			end
		end
	end
	assign tx_out = tx_r;
	assign rx_sampled_out = rx_sync_r[1];
	assign timestamp_out = ts_r;
	assign tec_out = tec_r;
	assign rec_out = rec_r;
	assign error_warning_flag_out = error_warning_flag_r;
	assign bus_off_flag_out = bus_off_flag_r;
	assign node_offline_out = off_r;
	// status only; nothing inside reads it
	assign suspend_acknowledge_out = sack_r;
	assign transmit_request_bit_out = transmit_request_bit_r;
	assign warn_irq_out = wirq_r;
	assign bus_off_flag_irq_out = birq_r;
	assign alert_irq_out = airq_r;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	ts_count_a: assert property (bit_tick_in |=>
		ts_r == $past(ts_r) + 16'h0001)
		else $error("time stamp did not step on a bit time");
	warn_irq_a: assert property ($rose(error_warning_flag_r) |-> wirq_r)
		else $error("warning set without interrupt");
	bus_off_flag_entry_a: assert property ($rose(bus_off_flag_r) |-> off_r && birq_r &&
		!error_warning_flag_r && tec_r == `CNEC_CNT_ONE_TEC && rec_r == `CNEC_CNT_ONE_REC)
		else $error("bus-off entry state wrong");
	recov_step_a: assert property (bus_off_flag_r && idle_seen_in &&
		idle_cnt_nxt != `CNEC_RECOV_IDLES |=> rec_r == $past(rec_r) + 8'h01)
		else $error("recovery did not count an idle time");
	recov_warn_a: assert property (bus_off_flag_r && $changed(rec_r) &&
		rec_r == `CNEC_WARN_DEF |-> error_warning_flag_r && wirq_r)
		else $error("no pre-warning at receive count 0x60");
	recov_end_a: assert property ($fell(bus_off_flag_r) |-> airq_r && !error_warning_flag_r &&
		off_r && $past(idle_cnt_r) == `CNEC_RECOV_IDLES - 8'h01)
		else $error("recovery end state wrong");
	sack_set_a: assert property (node_disable_bit_in && bus_idle_in |=>
		sack_r)
		else $error("suspend acknowledge missing");
	rx_sync_a: assert property ($past(reset_n_in, 2) |->
		rx_sampled_out == $past(rx_pin_in, 2))
		else $error("receive path delay is not two cycles");
	stt_clear_a: assert property (single_transmit_trial_in &&
		st_r == cnec_st_idle && st_nxt == cnec_st_sel && !transmit_request_bit_set_in |=> !transmit_request_bit_r)
		else $error("single trial request not cleared");
	stt_drop_a: assert property (st_r == cnec_st_sel && frame_err_in &&
		!transmit_request_bit_r && !transmit_request_bit_set_in |=> st_r == cnec_st_idle && !transmit_request_bit_r)
		else $error("single trial message retried");
	susp_off_a: assert property (susp_go |=> off_r)
		else $error("suspend did not force offline");
	off_quiet_a: assert property (off_r && st_r == cnec_st_idle |=>
		st_r != cnec_st_frame && tx_r)
		else $error("frame started while offline");
	bus_off_flag_seen_c: cover property ($rose(bus_off_flag_r));
	recov_done_c: cover property ($fell(bus_off_flag_r));
	stt_drop_c: cover property (st_r == cnec_st_sel && frame_err_in && !transmit_request_bit_r);
	buf_full_c: cover property (!wr_ready_out && wr_valid_in);
endmodule : cnec_node_ctrl
`default_nettype wire

// ---- verilog/cnec_consts.svh ----
`ifndef CNEC_CONSTS_SVH
`define CNEC_CONSTS_SVH
`define CNEC_WARN_DEF 8'h60
`define CNEC_CNT_ONE_TEC 9'h001
`define CNEC_CNT_ONE_REC 8'h01
`define CNEC_TEC_ERR_INC 9'h008
`define CNEC_TEC_BUS_OFF_FLAG_LIM 9'h0ff
`define CNEC_REC_MAX 8'hff
`define CNEC_RECOV_IDLES 8'h80
`define CNEC_BIT_LAST 3'h7
`define CNEC_BUF_FULL 2'h2
`define CNEC_RECESSIVE 1'b1
`define CNEC_DOMINANT 1'b0
`endif

// ---- verilog/cnec_pkg.sv ----
package cnec_pkg;
	typedef enum logic [2:0] {
		cnec_st_idle = 3'b001,
		cnec_st_sel = 3'b010,
		cnec_st_frame = 3'b100
	} cnec_tx_state_t;
endpackage : cnec_pkg

// ---- verif/cnec_bus_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module cnec_bus_model (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic tx_in,
	input wire logic dom_in,
	output logic rx_out,
	output logic tick_out,
	output logic idle_out
);
	logic [2:0] ph_r;
	logic [1:0] rec_r;
	logic long_r;
	// another node's dominant bit wins the wired-and bus
	assign rx_out = tx_in & ~dom_in;
	assign idle_out = (rec_r == 2'h3) & rx_out;
	// bit length alternates, as resynchronization would stretch it
	always_ff @(negedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ph_r <= 3'h0;
			long_r <= 1'b0;
			rec_r <= 2'h0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= (ph_r == 3'h0);
			if (ph_r == 3'h0) begin
				ph_r <= long_r ? 3'h4 : 3'h3;
				long_r <= ~long_r;
				if (!rx_out)
					rec_r <= 2'h0;
				else if (rec_r != 2'h3)
					rec_r <= rec_r + 2'h1;
			end else
				ph_r <= ph_r - 3'h1;
		end
	end
endmodule : cnec_bus_model
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk_in = 1'b0, reset_n_in = 1'b0, rx_dom = 1'b0;
	logic idle_seen_in = 1'b0, tx_err_in = 1'b0, tx_ok_in = 1'b0;
	logic rx_err_in = 1'b0, rx_ok_in = 1'b0, frame_err_in = 1'b0;
	logic warn_level_wr_in = 1'b0, offline_set_in = 1'b0;
	logic offline_clr_in = 1'b0, node_disable_bit_in = 1'b0;
	logic suspend_sensitivity_enable_in = 1'b0, suspend_req_in = 1'b0;
	logic single_transmit_trial_in = 1'b0, transmit_request_bit_set_in = 1'b0;
	logic wr_valid_in = 1'b0;
	logic [7:0] wr_data_in = 8'h00, warn_level_in = 8'h60;
	wire logic rx_pin_in, bit_tick_in, bus_idle_in;
	logic wr_ready_out, tx_out, rx_sampled_out, error_warning_flag_out;
	logic bus_off_flag_out, node_offline_out, suspend_acknowledge_out;
	logic transmit_request_bit_out, warn_irq_out, bus_off_flag_irq_out;
	logic alert_irq_out;
	logic [15:0] timestamp_out;
	logic [8:0] tec_out;
	logic [7:0] rec_out;
	int bad_count = 0, n_compared = 0, n_cyc = 0, n_tick = 0, n_dom = 0;
	int n_warn = 0, n_bus_off_flag = 0, n_alert = 0;
	logic [31:0] tx_bits = 32'h00000000;
	cnec_node_ctrl i_cnec_node_ctrl (.clk_in, .reset_n_in, .rx_pin_in,
		.bit_tick_in, .bus_idle_in, .idle_seen_in, .tx_err_in, .tx_ok_in,
		.rx_err_in, .rx_ok_in, .frame_err_in, .warn_level_wr_in,
		.warn_level_in, .offline_set_in, .offline_clr_in,
		.node_disable_bit_in, .suspend_sensitivity_enable_in,
		.suspend_req_in, .single_transmit_trial_in, .transmit_request_bit_set_in,
		.wr_valid_in, .wr_data_in, .wr_ready_out, .tx_out, .rx_sampled_out,
		.timestamp_out, .tec_out, .rec_out, .error_warning_flag_out,
		.bus_off_flag_out, .node_offline_out, .suspend_acknowledge_out,
		.transmit_request_bit_out, .warn_irq_out, .bus_off_flag_irq_out,
		.alert_irq_out);
	cnec_bus_model i_cnec_bus_model (.clk_in, .reset_n_in, .tx_in(tx_out),
		.dom_in(rx_dom), .rx_out(rx_pin_in), .tick_out(bit_tick_in),
		.idle_out(bus_idle_in));
	initial forever #12.5 clk_in = ~clk_in;
	task automatic stop_test();
		if (bad_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask : cyc
	task automatic hold(ref logic s, input int n);
		s = 1'b1;
		cyc(n);
		s = 1'b0;
		cyc(1);
	endtask : hold
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// the whole sequence needs about 600 cycles
	always @(posedge clk_in) begin
		n_cyc++;
		n_tick += bit_tick_in;
		n_dom += !tx_out;
		n_warn += warn_irq_out;
		n_bus_off_flag += bus_off_flag_irq_out;
		n_alert += alert_irq_out;
		// one transmit level per bit time, newest in bit 0
		if (bit_tick_in) begin
			tx_bits = {tx_bits[30:0], tx_out};
		end
		if (n_cyc == 5000) begin
			bad_count++;
			stop_test();
		end
	end
	initial begin
		int t0, d0, i;
		cyc(6);
		reset_n_in = 1'b1;
		cyc(1);
		chk("tx_out", 16'h1, tx_out);
		rx_dom = 1'b1;
		cyc(1);
		chk("rx_sync1", 16'h1, rx_sampled_out);
		cyc(1);
		chk("rx_sync2", 16'h0, rx_sampled_out);
		rx_dom = 1'b0;
		t0 = timestamp_out;
		d0 = n_tick;
		cyc(45);
		chk("timestamp", 16'(n_tick - d0), timestamp_out - 16'(t0));
		hold(offline_clr_in, 1);
		chk("offline_clr", 16'h0, node_offline_out);
		hold(rx_err_in, 95);
		chk("warn_early", 16'h0, error_warning_flag_out);
		hold(rx_err_in, 1);
		chk("warn_flag", 16'h1, error_warning_flag_out);
		chk("warn_irq", 16'h1, 16'(n_warn));
		hold(tx_err_in, 31);
		chk("tec", 16'hf8, tec_out);
		hold(tx_ok_in, 1);
		chk("tec_ok", 16'hf7, tec_out);
		hold(tx_err_in, 1);
		chk("tec_max", 16'hff, tec_out);
		chk("bus_off_flag_early", 16'h0, bus_off_flag_out);
		hold(tx_err_in, 1);
		chk("bus_off_flag", 16'h1, bus_off_flag_out);
		chk("tec_bus_off_flag", 16'h1, tec_out);
		chk("rec_bus_off_flag", 16'h1, rec_out);
		chk("offline", 16'h1, node_offline_out);
		chk("bus_off_flag_irq", 16'h1, 16'(n_bus_off_flag));
		hold(idle_seen_in, 94);
		chk("rec_recov", 16'h5f, rec_out);
		chk("prewarn_early", 16'h0, error_warning_flag_out);
		hold(idle_seen_in, 1);
		chk("prewarn", 16'h1, error_warning_flag_out & bus_off_flag_out);
		chk("prewarn_irq", 16'h2, 16'(n_warn));
		hold(idle_seen_in, 32);
		chk("bus_off_flag_recov", 16'h1, bus_off_flag_out);
		hold(idle_seen_in, 1);
		chk("flags_end", 16'h0, error_warning_flag_out | bus_off_flag_out);
		chk("alert_irq", 16'h1, 16'(n_alert));
		chk("offline_end", 16'h1, node_offline_out);
		warn_level_in = 8'h08;
		hold(warn_level_wr_in, 1);
		hold(rx_err_in, 7);
		chk("lvl_early", 16'h0, error_warning_flag_out);
		hold(rx_err_in, 1);
		chk("lvl_warn", 16'h1, error_warning_flag_out);
		chk("lvl_irq", 16'h3, 16'(n_warn));
		hold(rx_ok_in, 1);
		chk("rec_ok", 16'h7, rec_out);
		chk("lvl_clear", 16'h0, error_warning_flag_out);
		hold(offline_clr_in, 1);
		single_transmit_trial_in = 1'b1;
		d0 = n_dom;
		frame_err_in = 1'b1;
		hold(transmit_request_bit_set_in, 1);
		cyc(4);
		frame_err_in = 1'b0;
		cyc(30);
		chk("stt_transmit_request_bit", 16'h0, transmit_request_bit_out);
		chk("stt_lost", 16'(d0), 16'(n_dom));
		// delivery must not be lost here, so single trial stays off
		single_transmit_trial_in = 1'b0;
		wr_valid_in = 1'b1;
		wr_data_in = 8'ha5;
		cyc(1);
		wr_data_in = 8'h3c;
		cyc(1);
		wr_valid_in = 1'b0;
		chk("buf_full", 16'h0, wr_ready_out);
		frame_err_in = 1'b1;
		hold(transmit_request_bit_set_in, 1);
		cyc(3);
		frame_err_in = 1'b0;
		chk("retry_transmit_request_bit", 16'h1, transmit_request_bit_out);
		for (i = 0; i < 600 && transmit_request_bit_out !== 1'b0; i++)
			cyc(1);
		chk("sent", 16'h1, 16'(n_dom > d0));
		chk("tx_words", 16'ha53c, tx_bits[15:0]);
		chk("tx_start", 16'h2, 16'(tx_bits[17:16]));
		chk("sent_transmit_request_bit", 16'h0, transmit_request_bit_out);
		chk("buf_empty", 16'h1, wr_ready_out);
		rx_dom = 1'b1;
		cyc(30);
		node_disable_bit_in = 1'b1;
		cyc(3);
		chk("ack_busy", 16'h0, suspend_acknowledge_out);
		rx_dom = 1'b0;
		cyc(20);
		chk("ack", 16'h1, suspend_acknowledge_out);
		chk("ack_only", 16'h0, node_offline_out);
		node_disable_bit_in = 1'b0;
		cyc(2);
		chk("ack_drop", 16'h0, suspend_acknowledge_out);
		suspend_sensitivity_enable_in = 1'b1;
		suspend_req_in = 1'b1;
		cyc(2);
		chk("susp_offline", 16'h1, node_offline_out);
		suspend_req_in = 1'b0;
		hold(offline_set_in, 1);
		d0 = n_dom;
		hold(transmit_request_bit_set_in, 1);
		cyc(40);
		chk("offline_quiet", 16'(d0), 16'(n_dom));
		chk("offline_transmit_request_bit", 16'h1, transmit_request_bit_out);
		// node left offline, as needed before any module disable
		stop_test();
	end
endmodule : testbench
`default_nettype wire
